/* File: src/hca_params.svh */
// Purpose: constants of the heater current alarm compare block
// Assumes: currents in tenths of an ampere, 16-bit unsigned
// Notes:   word-aligned register offsets on a byte address bus
`ifndef HCA_PARAMS_SVH
`define HCA_PARAMS_SVH

`define HCA_CLK_MHZ          100
`define HCA_MIN_IVL_MS       100

`define HCA_AMPS_ZERO        16'h0000
`define HCA_AMPS_FULL        16'h01F4
`define HCA_AMPS_RANGE       16'h0226
`define HCA_AMPS_OVER        16'hFFFF

`define HCA_RST_BURN_THR     16'h0000
`define HCA_RST_OC_THR       16'h01F4
`define HCA_RST_SHORT_THR    16'h01F4
`define HCA_RST_CTRL         4'h0

`define HCA_OFS_CTRL         8'h00
`define HCA_OFS_BURN_THR     8'h04
`define HCA_OFS_OC_THR       8'h08
`define HCA_OFS_SHORT_THR_A  8'h0C
`define HCA_OFS_SHORT_THR_B  8'h10
`define HCA_OFS_STATUS       8'h14
`define HCA_OFS_MASK         8'h18
`define HCA_OFS_ALARM        8'h1C
`define HCA_OFS_LEAK_A       8'h20
`define HCA_OFS_LEAK_B       8'h24
`define HCA_OFS_HEAT_B       8'h28

`define HCA_CTRL_BURN_EN     0
`define HCA_CTRL_OC_EN       1
`define HCA_CTRL_SHORT_EN    2
`define HCA_CTRL_ALM1_ASSIGN 3

`define HCA_ALM_BURN         0
`define HCA_ALM_OC           1
`define HCA_ALM_SHORT_A      2
`define HCA_ALM_SHORT_B      3

`define HCA_SEL_NONE         2'h0
`define HCA_SEL_LEAK_A       2'h1
`define HCA_SEL_LEAK_B       2'h2
`define HCA_SEL_HEAT_B       2'h3

`endif

/* File: src/hca_pkg.sv */
// Purpose: types and compare functions of the heater current alarm block
// Assumes: thresholds already clamped to the settable range
// Notes:   the two end values of a threshold force the result
`include "hca_params.svh"
package hca_pkg;

   typedef logic [15:0] hca_amps_t;
   typedef logic [3:0]  hca_alarms_t;

   // under-current compare with forced ends
   function automatic logic hca_below(input hca_amps_t cur, input hca_amps_t thr);
      if (thr == `HCA_AMPS_ZERO) begin
         return 1'b0;
      end
      if (thr == `HCA_AMPS_FULL) begin
         return 1'b1;
      end
      return cur < thr;
   endfunction : hca_below

   // over-current compare with forced ends, shared by overcurrent and short
   function automatic logic hca_above(input hca_amps_t cur, input hca_amps_t thr);
      if (thr == `HCA_AMPS_FULL) begin
         return 1'b0;
      end
      if (thr == `HCA_AMPS_ZERO) begin
         return 1'b1;
      end
      return cur > thr;
   endfunction : hca_above

   // reading shown to the operator, over-range replaces the number
   function automatic hca_amps_t hca_reading(input hca_amps_t cur);
      return (cur > `HCA_AMPS_RANGE) ? `HCA_AMPS_OVER : cur;
   endfunction : hca_reading

   // byte-lane merge of a bus write
   function automatic logic [31:0] hca_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            m[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return m;
   endfunction : hca_merge

endpackage : hca_pkg

/* File: src/hca_timing_if.sv */
// Purpose: heating output timing between the alarm core and its interval timer
// Assumes: heat_on is a clean level in the core clock domain
// Notes:   long flags are registered in the timer
`timescale 1ns/1ns
interface hca_timing_if;
   logic heat_on;
   logic on_long;
   logic off_long;

   modport timer (input heat_on, output on_long, output off_long);
   modport user  (output heat_on, input on_long, input off_long);
endinterface : hca_timing_if

/* File: src/hca_interval.sv */
// Purpose: measures how long the heating output has stayed on or off
// Assumes: heat_on synchronous to core_clk
// Notes:   counter saturates, so very long intervals stay qualified
`timescale 1ns/1ns
module hca_interval #(
   parameter logic [23:0] MIN_CYC = 24'h989680
) (
   input  wire logic    core_clk,
   input  wire logic    rst,
   hca_timing_if.timer  tif
);

   logic [23:0] cnt;
   logic        prev_on;
   logic        steady;

   assign steady = (tif.heat_on == prev_on);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prev_on <= 1'b0;
      end else begin
         prev_on <= tif.heat_on;
      end
   end

   // restart on every edge of the output
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt <= 24'h000000;
      end else if (!steady) begin
         cnt <= 24'h000000;
      end else if (cnt <= MIN_CYC) begin
         cnt <= cnt + 24'h000001;
      end
   end

   // qualified only once the interval is strictly longer than the minimum
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tif.on_long  <= 1'b0;
         tif.off_long <= 1'b0;
      end else begin
         tif.on_long  <= steady && tif.heat_on && (cnt >= MIN_CYC);
         tif.off_long <= steady && !tif.heat_on && (cnt >= MIN_CYC);
      end
   end

endmodule : hca_interval

/* File: src/hca_top.sv */
// Purpose: heater burnout, overcurrent and short alarm compare with Wishbone registers
// Assumes: current samples in tenths of an ampere, valid for one cycle
// Notes:   channel b senses load current when on and leakage when off
//
// Behaviour
// - burnout alarm set when channel b current is below its threshold.
// - burnout threshold 0.0 forces alarm off, 50.0 forces it on.
// - overcurrent alarm set when channel b current exceeds its threshold.
// - overcurrent threshold 50.0 forces alarm off, 0.0 forces it on.
// - short alarm set when off-state leakage of a channel exceeds threshold.
// - short threshold 50.0 forces alarm off, 0.0 forces it on.
// - short thresholds settable 0.0 to 50.0 in tenths, reset to 50.0.
// - short evaluation skipped for off intervals of 100 ms or less.
// - leakage reading above 55.0 A shows the over-range code instead.
// - active short alarm lights lamp and flashes that channel's reading, channel a's if both are active.
// - short compare and leakage monitoring need enable and alarm 1 assigned.
// - burnout compare needs its enable and alarm 1 assigned.
// - overcurrent compare needs its enable and alarm 1 assigned.
// - burnout and overcurrent skipped for on intervals of 100 ms or less.
`timescale 1ns/1ns
`include "hca_params.svh"
module hca_top #(
   parameter int unsigned MIN_IVL_CYC = `HCA_MIN_IVL_MS * 1000 * `HCA_CLK_MHZ
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        sample_valid,
   input  wire logic        heat_output_on,
   input  wire logic [15:0] current_sensor_input_a,
   input  wire logic [15:0] current_sensor_input_b,
   output logic             alarm_out1,
   output logic             heater_alarm_lamp,
   output logic             display_flash,
   output logic      [1:0]  display_select,
   output logic      [15:0] leakage_reading_a,
   output logic      [15:0] leakage_reading_b,
   output logic             irq
);

   hca_timing_if tif ();

   hca_interval #(
      .MIN_CYC (24'(MIN_IVL_CYC))
   ) u_interval (
      .core_clk (core_clk),
      .rst      (rst),
      .tif      (tif.timer)
   );

   assign tif.heat_on = heat_output_on;

   logic [3:0]          ctrl;
   hca_pkg::hca_amps_t  burn_thr;
   hca_pkg::hca_amps_t  oc_thr;
   hca_pkg::hca_amps_t  short_thr_a;
   hca_pkg::hca_amps_t  short_thr_b;
   hca_pkg::hca_alarms_t alm;
   hca_pkg::hca_alarms_t alm_prev;
   hca_pkg::hca_alarms_t status;
   hca_pkg::hca_alarms_t mask;
   hca_pkg::hca_alarms_t next_status;
   hca_pkg::hca_alarms_t next_mask;
   hca_pkg::hca_amps_t  heat_reading_b;
   logic [31:0]         rd_mux;
   logic                wb_req;
   logic                wb_wr;
   logic                burn_run;
   logic                oc_run;
   logic                short_run;
   logic                eval_on;
   logic                eval_off;
   logic                oc_hit;
   logic                short_b_hit;

   assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr     = wb_req && wb_we_i;
   assign burn_run  = ctrl[`HCA_CTRL_BURN_EN] && ctrl[`HCA_CTRL_ALM1_ASSIGN];
   assign oc_run    = ctrl[`HCA_CTRL_OC_EN] && ctrl[`HCA_CTRL_ALM1_ASSIGN];
   assign short_run = ctrl[`HCA_CTRL_SHORT_EN] && ctrl[`HCA_CTRL_ALM1_ASSIGN];
   assign eval_on   = sample_valid && heat_output_on && tif.on_long;
   assign eval_off  = sample_valid && !heat_output_on && tif.off_long;

   // bus slave: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h00000000;
      end
   end

   // unmapped offsets read as zero and ignore writes
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (wb_adr_i)
         `HCA_OFS_CTRL:        rd_mux = {28'h0000000, ctrl};
         `HCA_OFS_BURN_THR:    rd_mux = {16'h0000, burn_thr};
         `HCA_OFS_OC_THR:      rd_mux = {16'h0000, oc_thr};
         `HCA_OFS_SHORT_THR_A: rd_mux = {16'h0000, short_thr_a};
         `HCA_OFS_SHORT_THR_B: rd_mux = {16'h0000, short_thr_b};
         `HCA_OFS_STATUS:      rd_mux = {28'h0000000, status};
         `HCA_OFS_MASK:        rd_mux = {28'h0000000, mask};
         `HCA_OFS_ALARM:       rd_mux = {28'h0000000, alm};
         `HCA_OFS_LEAK_A:      rd_mux = {16'h0000, leakage_reading_a};
         `HCA_OFS_LEAK_B:      rd_mux = {16'h0000, leakage_reading_b};
         `HCA_OFS_HEAT_B:      rd_mux = {16'h0000, heat_reading_b};
         default:              rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl <= `HCA_RST_CTRL;
      end else if (wb_wr && wb_adr_i == `HCA_OFS_CTRL && wb_sel_i[0]) begin
         ctrl <= wb_dat_i[3:0];
      end
   end

   // thresholds: out-of-range writes are dropped, the old value stays
   function automatic hca_pkg::hca_amps_t thr_wr(input hca_pkg::hca_amps_t old_v);
      logic [31:0] m;
      m = hca_pkg::hca_merge({16'h0000, old_v}, wb_dat_i, wb_sel_i);
      return (m <= {16'h0000, `HCA_AMPS_FULL}) ? m[15:0] : old_v;
   endfunction : thr_wr

   always_ff @(posedge core_clk) begin
      if (rst) begin
         burn_thr    <= `HCA_RST_BURN_THR;
         oc_thr      <= `HCA_RST_OC_THR;
         short_thr_a <= `HCA_RST_SHORT_THR;
         short_thr_b <= `HCA_RST_SHORT_THR;
      end else if (wb_wr) begin
         if (wb_adr_i == `HCA_OFS_BURN_THR) begin
            burn_thr <= thr_wr(burn_thr);
         end
         if (wb_adr_i == `HCA_OFS_OC_THR) begin
            oc_thr <= thr_wr(oc_thr);
         end
         if (wb_adr_i == `HCA_OFS_SHORT_THR_A) begin
            short_thr_a <= thr_wr(short_thr_a);
         end
         if (wb_adr_i == `HCA_OFS_SHORT_THR_B) begin
            short_thr_b <= thr_wr(short_thr_b);
         end
      end
   end

   // alarms hold between qualified samples; disabling clears at once
   always_ff @(posedge core_clk) begin
      if (rst) begin
         alm <= 4'h0;
      end else begin
         if (!burn_run) begin
            alm[`HCA_ALM_BURN] <= 1'b0;
         end else if (eval_on) begin
            alm[`HCA_ALM_BURN] <= hca_pkg::hca_below(current_sensor_input_b,
                                                     burn_thr);
         end
         if (!oc_run) begin
            alm[`HCA_ALM_OC] <= 1'b0;
         end else if (eval_on) begin
            alm[`HCA_ALM_OC] <= hca_pkg::hca_above(current_sensor_input_b,
                                                   oc_thr);
         end
         if (!short_run) begin
            alm[`HCA_ALM_SHORT_A] <= 1'b0;
            alm[`HCA_ALM_SHORT_B] <= 1'b0;
         end else if (eval_off) begin
            alm[`HCA_ALM_SHORT_A] <= hca_pkg::hca_above(current_sensor_input_a,
                                                        short_thr_a);
            alm[`HCA_ALM_SHORT_B] <= hca_pkg::hca_above(current_sensor_input_b,
                                                        short_thr_b);
         end
      end
   end

   // monitors follow every off-state sample while short_run is set, even short intervals
   always_ff @(posedge core_clk) begin
      if (rst) begin
         leakage_reading_a <= `HCA_AMPS_ZERO;
         leakage_reading_b <= `HCA_AMPS_ZERO;
      end else if (sample_valid && !heat_output_on && short_run) begin
         leakage_reading_a <= hca_pkg::hca_reading(current_sensor_input_a);
         leakage_reading_b <= hca_pkg::hca_reading(current_sensor_input_b);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         heat_reading_b <= `HCA_AMPS_ZERO;
      end else if (sample_valid && heat_output_on && (burn_run || oc_run)) begin
         heat_reading_b <= hca_pkg::hca_reading(current_sensor_input_b);
      end
   end

   // operator outputs, one cycle behind the alarm flops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         alarm_out1        <= 1'b0;
         heater_alarm_lamp <= 1'b0;
         display_flash     <= 1'b0;
         display_select    <= `HCA_SEL_NONE;
      end else begin
         alarm_out1        <= |alm;
         heater_alarm_lamp <= |alm;
         display_flash     <= |alm;
         if (alm[`HCA_ALM_SHORT_A]) begin
            display_select <= `HCA_SEL_LEAK_A;
         end else if (alm[`HCA_ALM_SHORT_B]) begin
            display_select <= `HCA_SEL_LEAK_B;
         end else if (alm[`HCA_ALM_BURN] || alm[`HCA_ALM_OC]) begin
            display_select <= `HCA_SEL_HEAT_B;
         end else begin
            display_select <= `HCA_SEL_NONE;
         end
      end
   end

   // sticky events: a new rise wins over a same-cycle clear
   always_comb begin
      next_status = status;
      if (wb_wr && wb_adr_i == `HCA_OFS_STATUS && wb_sel_i[0]) begin
         next_status = status & ~wb_dat_i[3:0];
      end
      next_status = next_status | (alm & ~alm_prev);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         alm_prev <= 4'h0;
         status   <= 4'h0;
         irq      <= 1'b0;
      end else begin
         alm_prev <= alm;
         status   <= next_status;
         irq      <= |(next_status & next_mask);
      end
   end

   // irq reads next_mask, so a mask write shows at the interrupt in step with mask
   always_comb begin
      next_mask = mask;
      if (wb_wr && wb_adr_i == `HCA_OFS_MASK && wb_sel_i[0]) begin
         next_mask = wb_dat_i[3:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         mask <= 4'h0;
      end else begin
         mask <= next_mask;
      end
   end

   // plain compares, so the checks below do not reuse the design's functions
   assign oc_hit      = current_sensor_input_b > oc_thr;
   assign short_b_hit = current_sensor_input_b > short_thr_b;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence on_sample_s;
      eval_on && burn_run && burn_thr != `HCA_AMPS_ZERO && burn_thr != `HCA_AMPS_FULL;
   endsequence

   sequence short_raise_s;
      !alm[`HCA_ALM_SHORT_A] ##1 alm[`HCA_ALM_SHORT_A];
   endsequence

   burn_below_a: assert property (on_sample_s and (current_sensor_input_b < burn_thr)
      |=> alm[`HCA_ALM_BURN] ##1 alarm_out1)
      else $error("burnout alarm missed below threshold");
   burn_above_a: assert property (on_sample_s and (current_sensor_input_b >= burn_thr)
      |=> !alm[`HCA_ALM_BURN])
      else $error("burnout alarm set at or above threshold");
   burn_force_a: assert property (eval_on && burn_run && burn_thr == `HCA_AMPS_FULL
      |=> alm[`HCA_ALM_BURN])
      else $error("burnout full threshold did not force alarm");
   oc_above_a: assert property (eval_on && oc_run && oc_thr != `HCA_AMPS_ZERO
      && oc_thr != `HCA_AMPS_FULL
      |=> alm[`HCA_ALM_OC] == $past(oc_hit))
      else $error("overcurrent compare wrong");
   oc_force_a: assert property (eval_on && oc_run && oc_thr == `HCA_AMPS_ZERO
      |=> alm[`HCA_ALM_OC])
      else $error("overcurrent zero threshold did not force alarm");
   short_cmp_a: assert property (eval_off && short_run && short_thr_b != `HCA_AMPS_ZERO
      && short_thr_b != `HCA_AMPS_FULL
      |=> alm[`HCA_ALM_SHORT_B] == $past(short_b_hit))
      else $error("short compare wrong on channel b");
   short_off_a: assert property (eval_off && short_thr_a == `HCA_AMPS_FULL
      |=> !alm[`HCA_ALM_SHORT_A])
      else $error("short full threshold did not force alarm off");
   thr_range_a: assert property (short_thr_a <= `HCA_AMPS_FULL
      && ($past(rst) -> short_thr_b == `HCA_RST_SHORT_THR))
      else $error("short threshold out of range or wrong default");
   short_skip_a: assert property (sample_valid && !heat_output_on && !tif.off_long
      && short_run |=> $stable(alm[`HCA_ALM_SHORT_A]))
      else $error("short alarm changed on a short off interval");
   over_range_a: assert property (sample_valid && !heat_output_on && short_run
      && current_sensor_input_a > `HCA_AMPS_RANGE
      |=> leakage_reading_a == `HCA_AMPS_OVER)
      else $error("over-range code not shown");
   lamp_flash_a: assert property (short_raise_s
      |=> heater_alarm_lamp && display_flash && display_select == `HCA_SEL_LEAK_A)
      else $error("short alarm did not light lamp and flash reading");
   select_b_a: assert property (alm[`HCA_ALM_SHORT_B] && !alm[`HCA_ALM_SHORT_A]
      |=> display_select == `HCA_SEL_LEAK_B)
      else $error("short b alarm did not select its reading");
   short_gate_a: assert property (!short_run
      |=> !alm[`HCA_ALM_SHORT_A] && !alm[`HCA_ALM_SHORT_B])
      else $error("short alarm active while disabled");
   leak_hold_a: assert property (sample_valid && !heat_output_on && !short_run
      |=> $stable(leakage_reading_a) && $stable(leakage_reading_b))
      else $error("leakage reading moved while monitoring disabled");
   burn_gate_a: assert property (!burn_run |=> !alm[`HCA_ALM_BURN])
      else $error("burnout alarm active while disabled");
   oc_gate_a: assert property (!oc_run |=> !alm[`HCA_ALM_OC])
      else $error("overcurrent alarm active while disabled");
   on_skip_a: assert property (sample_valid && heat_output_on && !tif.on_long
      && burn_run && oc_run |=> $stable(alm[`HCA_ALM_BURN]) && $stable(alm[`HCA_ALM_OC]))
      else $error("burnout or overcurrent changed on a short on interval");
   out_or_a: assert property (##1 alarm_out1 == |$past(alm))
      else $error("alarm output not the OR of alarms");
   status_set_a: assert property (alm[`HCA_ALM_BURN] && !alm_prev[`HCA_ALM_BURN]
      |=> status[`HCA_ALM_BURN])
      else $error("status missed a burnout alarm rise");
   irq_level_a: assert property (irq == |(status & mask))
      else $error("interrupt does not follow unmasked status");
   wb_ack_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single cycle");

endmodule : hca_top

/* File: tb/hca_sensor_model.sv */
// Purpose: current sensor and heating output stand-in
// Assumes: one sample every four cycles
// Notes:   currents inverted between samples so stale values show
`timescale 1ns/1ns
module hca_sensor_model (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        heat_cmd,
   input  wire logic [15:0] cur_a,
   input  wire logic [15:0] cur_b,
   output logic             sample_valid,
   output logic             heat_output_on,
   output logic      [15:0] current_sensor_input_a,
   output logic      [15:0] current_sensor_input_b
);
   logic [1:0] phase;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         phase          <= 2'h0;
         sample_valid   <= 1'b0;
         heat_output_on <= 1'b0;
      end else begin
         phase          <= phase + 2'h1;
         sample_valid   <= (phase == 2'h3);
         heat_output_on <= heat_cmd;
      end
   end
   always_ff @(posedge core_clk) begin
      current_sensor_input_a <= (phase == 2'h3) ? cur_a : ~cur_a;
      current_sensor_input_b <= (phase == 2'h3) ? cur_b : ~cur_b;
   end
endmodule : hca_sensor_model

/* File: tb/test_heater_current_alarm_compare.sv */
// Purpose: register-level test of the heater alarm compare block
// Assumes: interval cut to 20 cycles
// Notes:   fixed settle covers interval plus sample spacing
`timescale 1ns/1ns
`include "hca_params.svh"
module test_heater_current_alarm_compare;
   localparam int unsigned IVL = 20;
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        cyc      = 1'b0;
   logic        stb      = 1'b0;
   logic        we       = 1'b0;
   logic [7:0]  adr      = 8'h00;
   logic [31:0] dat      = 32'h0;
   logic        heat_cmd = 1'b0;
   logic [15:0] cur_a    = 16'h0;
   logic [15:0] cur_b    = 16'h0;
   logic [31:0] rdat;
   logic        ack, sv, heat, alm, lamp, flash, irq;
   logic [15:0] sa, sb, la, lb;
   logic [1:0]  dsel;
   int          fails    = 0;
   int          checks   = 0;

   always #5 core_clk = ~core_clk;

   hca_sensor_model u_hca_sensor_model (.core_clk(core_clk), .rst(rst), .heat_cmd(heat_cmd),
      .cur_a(cur_a), .cur_b(cur_b), .sample_valid(sv), .heat_output_on(heat),
      .current_sensor_input_a(sa), .current_sensor_input_b(sb));
   hca_top #(.MIN_IVL_CYC(IVL)) u_hca_top (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .sample_valid(sv), .heat_output_on(heat),
      .current_sensor_input_a(sa), .current_sensor_input_b(sb), .alarm_out1(alm),
      .heater_alarm_lamp(lamp), .display_flash(flash), .display_select(dsel),
      .leakage_reading_a(la), .leakage_reading_b(lb), .irq(irq));

   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask : chk

   // one classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         fails++;
         give_verdict();
      end
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(q, e, m);
   endtask : rd

   task automatic env(input logic h, input logic [15:0] a, input logic [15:0] b);
      @(posedge core_clk);
      heat_cmd <= h;
      cur_a    <= a;
      cur_b    <= b;
      repeat (IVL + 16) @(posedge core_clk);
   endtask : env

   // heat level h held only 16 cycles, shorter than the interval
   task automatic pulses(input logic h);
      int bad;
      bad = 0;
      repeat (3) begin
         @(posedge core_clk) heat_cmd <= h;
         repeat (16) @(posedge core_clk) bad += (alm !== 1'b0);
         heat_cmd <= ~h;
         repeat (30) @(posedge core_clk) bad += (alm !== 1'b0);
      end
      chk(32'(bad), 32'h0, "alarm in short interval");
   endtask : pulses

   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      rd(`HCA_OFS_BURN_THR, 32'h0, "burn thr reset");
      rd(`HCA_OFS_OC_THR, 32'h1F4, "oc thr reset");
      rd(`HCA_OFS_SHORT_THR_A, 32'h1F4, "short a reset");
      rd(`HCA_OFS_SHORT_THR_B, 32'h1F4, "short b reset");
      rd(8'h3C, 32'h0, "unmapped read");
      wr(`HCA_OFS_SHORT_THR_A, 32'h1F5);
      rd(`HCA_OFS_SHORT_THR_A, 32'h1F4, "over 50.0 accepted");
      $display("test reset done");
      wr(`HCA_OFS_MASK, 32'hF);
      wr(`HCA_OFS_CTRL, 32'h9);
      wr(`HCA_OFS_BURN_THR, 32'h64);
      env(1'b1, 16'h0, 16'h63);
      rd(`HCA_OFS_ALARM, 32'h1, "burnout missing");
      chk(32'({alm, lamp, flash, irq}), 32'hF, "alarm outputs");
      chk(32'(dsel), 32'h3, "burn display");
      env(1'b1, 16'h0, 16'h64);
      rd(`HCA_OFS_ALARM, 32'h0, "burnout at threshold");
      rd(`HCA_OFS_STATUS, 32'h1, "status not sticky");
      wr(`HCA_OFS_MASK, 32'h0);
      chk(32'(irq), 32'h0, "masked irq");
      wr(`HCA_OFS_MASK, 32'h1);
      chk(32'(irq), 32'h1, "irq unmasked");
      wr(`HCA_OFS_STATUS, 32'h1);
      rd(`HCA_OFS_STATUS, 32'h0, "status clear");
      chk(32'(irq), 32'h0, "irq after clear");
      wr(`HCA_OFS_BURN_THR, 32'h0);
      env(1'b1, 16'h0, 16'h0);
      rd(`HCA_OFS_ALARM, 32'h0, "burn 0.0 not off");
      wr(`HCA_OFS_BURN_THR, 32'h1F4);
      env(1'b1, 16'h0, 16'h226);
      rd(`HCA_OFS_ALARM, 32'h1, "burn 50.0 not on");
      wr(`HCA_OFS_CTRL, 32'h1);
      env(1'b1, 16'h0, 16'h0);
      rd(`HCA_OFS_ALARM, 32'h0, "burn without alarm 1");
      $display("test burnout done");
      wr(`HCA_OFS_CTRL, 32'hA);
      wr(`HCA_OFS_OC_THR, 32'h64);
      env(1'b1, 16'h0, 16'h65);
      rd(`HCA_OFS_ALARM, 32'h2, "overcurrent missing");
      env(1'b1, 16'h0, 16'h64);
      rd(`HCA_OFS_ALARM, 32'h0, "overcurrent at threshold");
      wr(`HCA_OFS_OC_THR, 32'h1F4);
      env(1'b1, 16'h0, 16'h226);
      rd(`HCA_OFS_ALARM, 32'h0, "oc 50.0 not off");
      wr(`HCA_OFS_OC_THR, 32'h0);
      env(1'b1, 16'h0, 16'h0);
      rd(`HCA_OFS_ALARM, 32'h2, "oc 0.0 not on");
      wr(`HCA_OFS_CTRL, 32'h2);
      rd(`HCA_OFS_ALARM, 32'h0, "oc without alarm 1");
      $display("test overcurrent done");
      wr(`HCA_OFS_CTRL, 32'hC);
      wr(`HCA_OFS_SHORT_THR_A, 32'h64);
      wr(`HCA_OFS_SHORT_THR_B, 32'h64);
      env(1'b0, 16'h65, 16'h64);
      rd(`HCA_OFS_ALARM, 32'h4, "short a");
      chk(32'({lamp, flash, dsel}), 32'hD, "short a display");
      env(1'b0, 16'h64, 16'h65);
      rd(`HCA_OFS_ALARM, 32'h8, "short b");
      chk(32'({lamp, flash, dsel}), 32'hE, "short b display");
      wr(`HCA_OFS_SHORT_THR_A, 32'h0);
      wr(`HCA_OFS_SHORT_THR_B, 32'h1F4);
      env(1'b0, 16'h227, 16'h226);
      rd(`HCA_OFS_ALARM, 32'h4, "short forced ends");
      chk({la, lb}, 32'hFFFF0226, "over-range readings");
      rd(`HCA_OFS_LEAK_B, 32'h226, "leak b at 55.0");
      wr(`HCA_OFS_CTRL, 32'h4);
      rd(`HCA_OFS_ALARM, 32'h0, "short without alarm 1");
      chk(32'(dsel), 32'h0, "display after disable");
      $display("test short done");
      wr(`HCA_OFS_CTRL, 32'hB);
      env(1'b0, 16'h0, 16'h0);
      pulses(1'b1);
      env(1'b1, 16'h0, 16'h0);
      rd(`HCA_OFS_ALARM, 32'h3, "burn and oc after long on");
      wr(`HCA_OFS_CTRL, 32'hC);
      pulses(1'b0);
      $display("test intervals done");
      give_verdict();
   end
endmodule : test_heater_current_alarm_compare
